// [erg_top.sv]
// register file, excitation routing and shared digital pins
`timescale 1ns/100ps
// Operation
// - upper nibble of routing register steers first source; codes 0-7 pick analog inputs.
// - codes 10x0 to excitation pin one, 10x1 to pin two, 11xx disconnected.
// - lower nibble steers second source with identical encoding.
// - routing register at 0Bh, resets to FFh so both sources start off.
// - function enable register at 0Ch, reset 00h; one enables pin function.
// - bits 7..2 map to analog inputs 7..2, bit 1 negative ref, bit 0 positive.
// - direction register at 0Dh, reset zero; zero output, one input.
// - data register at 0Eh, reset zero; zero low, one high.
// - output pin data reads back the stored register bit.
// - writing data for an input pin only updates the stored value.
module erg_top
   import erg_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic [7:0] pin_level_i,
   output logic      [7:0] pin_out_o,
   output logic      [7:0] pin_oe_o,
   output logic      [7:0] src_one_ain_o,
   output logic            src_one_pin_one_o,
   output logic            src_one_pin_two_o,
   output logic      [7:0] src_two_ain_o,
   output logic            src_two_pin_one_o,
   output logic            src_two_pin_two_o
);
   typedef struct packed {
      logic [7:0] route;
      logic [7:0] func;
      logic [7:0] dir;
      logic [7:0] data;
      logic [7:0] rdata;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] s1_ain;
      logic       s1_p1;
      logic       s1_p2;
      logic [7:0] s2_ain;
      logic       s2_p1;
      logic       s2_p2;
   } erg_state_s;

   erg_state_s st_q;
   erg_state_s st_d;
   logic [7:0] dec1_ain;
   logic       dec1_p1;
   logic       dec1_p2;
   logic [7:0] dec2_ain;
   logic       dec2_p1;
   logic       dec2_p2;

   // decode from next-state routing so switch outputs track the register without lag
   erg_route_decode u_dec_one (
      .code_i    (st_d.route[ERG_SRC1_HI:ERG_SRC1_LO]),
      .ain_sel_o (dec1_ain),
      .pin_one_o (dec1_p1),
      .pin_two_o (dec1_p2)
   );

   erg_route_decode u_dec_two (
      .code_i    (st_d.route[ERG_SRC2_HI:ERG_SRC2_LO]),
      .ain_sel_o (dec2_ain),
      .pin_one_o (dec2_p1),
      .pin_two_o (dec2_p2)
   );

   // data readback: inputs that are enabled show the pin, all else the stored bit
   function automatic logic [7:0] data_view(input logic [7:0] data, input logic [7:0] func,
                                            input logic [7:0] dir, input logic [7:0] lvl);
      logic [7:0] in_mask;
      in_mask   = func & dir;
      data_view = (data & ~in_mask) | (lvl & in_mask);
   endfunction

   always_comb begin
      st_d = st_q;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            ERG_ADDR_ROUTE: st_d.route = reg_wdata_i;
            ERG_ADDR_FUNC:  st_d.func  = reg_wdata_i;
            ERG_ADDR_DIR:   st_d.dir   = reg_wdata_i;
            ERG_ADDR_DATA:  st_d.data  = reg_wdata_i;
            default: ;
         endcase
      end
      st_d.rdata = st_q.rdata;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            ERG_ADDR_ROUTE: st_d.rdata = st_q.route;
            ERG_ADDR_FUNC:  st_d.rdata = st_q.func;
            ERG_ADDR_DIR:   st_d.rdata = st_q.dir;
            ERG_ADDR_DATA:  st_d.rdata = data_view(st_q.data, st_q.func, st_q.dir, pin_level_i);
            default:        st_d.rdata = ERG_ZERO_BYTE;
         endcase
      end
      // bit n of each register owns the same shared pin n
      st_d.pin_oe  = st_d.func & ~st_d.dir;
      st_d.pin_out = st_d.data & st_d.pin_oe;
      st_d.s1_ain  = dec1_ain;
      st_d.s1_p1   = dec1_p1;
      st_d.s1_p2   = dec1_p2;
      st_d.s2_ain  = dec2_ain;
      st_d.s2_p1   = dec2_p1;
      st_d.s2_p2   = dec2_p2;
      if (!reset_n_i) begin
         st_d = '0;
         st_d.route = ERG_RST_ROUTE;
         st_d.func  = ERG_RST_FUNC;
         st_d.dir   = ERG_RST_DIR;
         st_d.data  = ERG_RST_DATA;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      st_q <= st_d;
   end

   assign reg_rdata_o       = st_q.rdata;
   assign pin_out_o         = st_q.pin_out;
   assign pin_oe_o          = st_q.pin_oe;
   assign src_one_ain_o     = st_q.s1_ain;
   assign src_one_pin_one_o = st_q.s1_p1;
   assign src_one_pin_two_o = st_q.s1_p2;
   assign src_two_ain_o     = st_q.s2_ain;
   assign src_two_pin_one_o = st_q.s2_p1;
   assign src_two_pin_two_o = st_q.s2_p2;
endmodule

// [erg_pkg.sv]
// shared constants for the excitation routing and pin logic block
package erg_pkg;
   localparam logic [3:0] ERG_ADDR_ROUTE   = 4'hb;
   localparam logic [3:0] ERG_ADDR_FUNC    = 4'hc;
   localparam logic [3:0] ERG_ADDR_DIR     = 4'hd;
   localparam logic [3:0] ERG_ADDR_DATA    = 4'he;
   localparam logic [7:0] ERG_RST_ROUTE    = 8'hff;
   localparam logic [7:0] ERG_RST_FUNC     = 8'h00;
   localparam logic [7:0] ERG_RST_DIR      = 8'h00;
   localparam logic [7:0] ERG_RST_DATA     = 8'h00;
   localparam int         ERG_SRC1_HI      = 7;
   localparam int         ERG_SRC1_LO      = 4;
   localparam int         ERG_SRC2_HI      = 3;
   localparam int         ERG_SRC2_LO      = 0;
   localparam logic [7:0] ERG_ZERO_BYTE    = 8'h00;
   localparam logic [1:0] ERG_CODE_PIN     = 2'h2;
   localparam logic [1:0] ERG_CODE_OFF     = 2'h3;
   localparam logic [2:0] ERG_ZERO_SEL     = 3'h0;

   typedef enum logic [1:0] {
      ERG_DEST_NONE,
      ERG_DEST_AIN,
      ERG_DEST_PIN_ONE,
      ERG_DEST_PIN_TWO
   } erg_dest_e;
endpackage

// [erg_route_decode.sv]
// decodes one four-bit routing code into one-hot switch controls
`timescale 1ns/100ps
module erg_route_decode
   import erg_pkg::*;
(
   input  wire logic [3:0] code_i,
   output logic      [7:0] ain_sel_o,
   output logic            pin_one_o,
   output logic            pin_two_o
);
   always_comb begin
      ain_sel_o = ERG_ZERO_BYTE;
      pin_one_o = 1'b0;
      pin_two_o = 1'b0;
      if (code_i[3] == 1'b0) begin
         ain_sel_o[code_i[2:0]] = 1'b1;
      end else if (code_i[3:2] == ERG_CODE_PIN) begin
         pin_one_o = ~code_i[0];
         pin_two_o = code_i[0];
      end
      // codes 11xx fall through disconnected
   end
endmodule

// [erg_top_sva.sv]
// port assertions for the routing and pin block
`timescale 1ns/100ps
module erg_top_sva (
   input wire logic       clk_sys_i,
   input wire logic       reset_n_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] pin_out_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic [7:0] src_one_ain_o,
   input wire logic [7:0] src_two_ain_o,
   input wire logic       src_two_pin_one_o,
   input wire logic       src_two_pin_two_o
);
   wire wb = reg_wr_i && reg_addr_i == 4'hb;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   property p_r1; wb && !reg_wdata_i[7] |=> src_one_ain_o == 8'h01 << $past(reg_wdata_i[6:4]); endproperty
   a_r1: assert property (p_r1) else $error("src one ain");
   property p_off; wb && &reg_wdata_i[7:6] |=> src_one_ain_o == 8'h00; endproperty
   a_off: assert property (p_off) else $error("src one off");
   property p_two; wb && reg_wdata_i[3:2] == 2'h2 |=>
      {src_two_pin_two_o, src_two_pin_one_o} == 2'h1 << $past(reg_wdata_i[0]) && src_two_ain_o == 8'h00; endproperty
   a_two: assert property (p_two) else $error("src two pin");
   property p_rst; $rose(reset_n_i) |-> src_two_ain_o == 8'h00 && !src_two_pin_one_o && pin_oe_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_drv; (pin_out_o & ~pin_oe_o) == 8'h00; endproperty
   a_drv: assert property (p_drv) else $error("undriven pin high");
   property p_dat; reg_wr_i && reg_addr_i == 4'he |=> pin_out_o == ($past(reg_wdata_i) & pin_oe_o); endproperty
   a_dat: assert property (p_dat) else $error("pin data");
   property p_oe; !reg_wr_i |=> $stable(pin_oe_o); endproperty
   a_oe: assert property (p_oe) else $error("enable moved");
   property p_rd; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
   a_rd: assert property (p_rd) else $error("read data moved");
endmodule
bind erg_top erg_top_sva erg_top_sva_i (.*);

// [erg_host.sv]
// host register access model, strobes launched after a rising edge
`timescale 1ns/100ps
module erg_host (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic            wr_o = 1'b0,
   output logic            rd_o = 1'b0,
   output logic      [3:0] addr_o = 4'h0,
   output logic      [7:0] wdata_o = 8'h00
);
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask
   // answer is registered, so take it one edge after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      {rd_o, addr_o} <= {1'b1, a};
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(posedge clk_i);
      d = rdata_i;
   endtask
endmodule

// [erg_top_test.sv]
// self-checking bench for the routing and pin block
`timescale 1ns/100ps
module erg_top_test;
   logic       clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i, reg_rd_i;
   logic       src_one_pin_one_o, src_one_pin_two_o, src_two_pin_one_o, src_two_pin_two_o;
   logic [3:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, pin_level_i = 8'h00, pin_out_o, pin_oe_o, src_one_ain_o, src_two_ain_o;
   logic [7:0] f, d, v, x, r;
   int         n_fail = 0, n_checks = 0, seed = 65;
   erg_top erg_top_i (.*);
   erg_host erg_host_i (.clk_i(clk_sys_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
      .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   always #5 clk_sys_i = ~clk_sys_i;
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   function logic [9:0] rt(input logic [3:0] c);
      rt = {c[3] ? 8'h00 : 8'h01 << c[2:0], c[3:2] == 2'h2 && !c[0], c[3:2] == 2'h2 && c[0]};
   endfunction
   task wrap_up;
      if (n_fail == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         erg_host_i.rd(4'hb + i[3:0], r);
         chk(r, i == 0 ? 8'hff : 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         erg_host_i.wr(4'hb, {i[3:0], 4'hf - i[3:0]});
         @(negedge clk_sys_i);
         chk({src_one_ain_o, src_one_pin_one_o, src_one_pin_two_o}, rt(i[3:0]));
         chk({src_two_ain_o, src_two_pin_one_o, src_two_pin_two_o}, rt(4'hf - i[3:0]));
      end
      // first two passes: all outputs, then all inputs
      for (int i = 0; i < 30; i++) begin
         {f, d, v, x} = $random(seed);
         if (i < 2)
            {f, d} = {8'hff, {8{i[0]}}};
         erg_host_i.wr(4'hc, f);
         erg_host_i.wr(4'hd, d);
         erg_host_i.wr(4'he, v);
         @(posedge clk_sys_i) pin_level_i <= x;
         erg_host_i.rd(4'he, r);
         chk(r, (f & d & x) | (v & ~(f & d)));
         chk({pin_oe_o, pin_out_o}, {f & ~d, v & f & ~d});
         erg_host_i.rd(4'hc, r);
         chk(r, f);
         erg_host_i.rd(4'hd, r);
         chk(r, d);
      end
      erg_host_i.rd(4'h3, r);
      chk(r, 8'h00);
      // mid-run reset with pins possibly driven: all must fall back to reset state
      @(posedge clk_sys_i) reset_n_i <= 1'b0;
      @(posedge clk_sys_i) reset_n_i <= 1'b1;
      @(negedge clk_sys_i);
      chk({pin_oe_o, src_one_ain_o}, 16'h0000);
      chk({pin_out_o, src_two_ain_o}, 16'h0000);
      erg_host_i.rd(4'hb, r);
      chk(r, 8'hff);
      erg_host_i.rd(4'hc, r);
      chk(r, 8'h00);
      wrap_up();
   end
endmodule
